// ### rtl/dcc_pkg.sv
// shared constants for the dual comparator control block
package dcc_pkg;
    localparam logic [11:0] DCC_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] DCC_IRQ_STATUS_OFFSET = 12'h004;
    localparam logic [11:0] DCC_IRQ_MASK_OFFSET = 12'h008;
    localparam int DCC_IDLE_SUPPRESS_BIT = 15;
    localparam int DCC_RESERVED_BIT = 14;
    localparam int DCC_B_FLAG_BIT = 13;
    localparam int DCC_A_FLAG_BIT = 12;
    localparam int DCC_B_ON_BIT = 11;
    localparam int DCC_A_ON_BIT = 10;
    localparam int DCC_B_PAD_BIT = 9;
    localparam int DCC_A_PAD_BIT = 8;
    localparam int DCC_B_RESULT_BIT = 7;
    localparam int DCC_A_RESULT_BIT = 6;
    localparam int DCC_B_INV_BIT = 5;
    localparam int DCC_A_INV_BIT = 4;
    localparam int DCC_B_MINUS_BIT = 3;
    localparam int DCC_B_PLUS_BIT = 2;
    localparam int DCC_A_MINUS_BIT = 1;
    localparam int DCC_A_PLUS_BIT = 0;
    // writable control bits: 15, 11..8, 5..0
    localparam logic [15:0] DCC_CTRL_WMASK = 16'h8F3F;
    localparam logic [15:0] DCC_CTRL_RESET = 16'h0000;
    localparam logic [1:0] DCC_IRQ_RESET = 2'h0;
    localparam logic [1:0] DCC_AXI_OKAY = 2'h0;
    localparam logic [1:0] DCC_AXI_SLVERR = 2'h2;
endpackage

// ### rtl/dcc_sync.sv
// two-flop synchroniser with change detect on the settled value
`timescale 1ns/1ps
module dcc_sync
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic async_in,
    output logic level_out,
    output logic change_out
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
    } dcc_sync_t;

    dcc_sync_t s_reg;
    dcc_sync_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.meta = async_in;
        s_next.stable = s_reg.meta;
        s_next.last = s_reg.stable;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign level_out = s_reg.stable;
    assign change_out = s_reg.stable ^ s_reg.last;
endmodule

// ### rtl/dcc_top.sv
// dual comparator control: axi4-lite registers, routing, flags, interrupt
`timescale 1ns/1ps
module dcc_top
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic device_idle,
    input wire logic cmp_a_raw,
    input wire logic cmp_b_raw,
    output logic cmp_a_on,
    output logic cmp_b_on,
    output logic cmp_a_plus_route,
    output logic cmp_a_minus_route,
    output logic cmp_b_plus_route,
    output logic cmp_b_minus_route,
    output logic cmp_a_pad_out,
    output logic cmp_a_pad_oe_n,
    output logic cmp_b_pad_out,
    output logic cmp_b_pad_oe_n,
    output logic irq,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic idle_meta;
        logic idle_sync;
        logic [11:0] awaddr;
        logic aw_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_held;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic a_pad;
        logic b_pad;
        logic a_oe_n;
        logic b_oe_n;
        logic irq;
    } dcc_state_t;

    dcc_state_t st_reg;
    dcc_state_t st_next;

    logic a_level;
    logic a_change;
    logic b_level;
    logic b_change;
    logic a_result;
    logic b_result;

    dcc_sync u_sync_a
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(cmp_a_raw),
        .level_out(a_level),
        .change_out(a_change)
    );

    dcc_sync u_sync_b
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(cmp_b_raw),
        .level_out(b_level),
        .change_out(b_change)
    );

    // a disabled comparator reports low; its flag then sees no edges
    assign a_result = st_reg.ctrl[dcc_pkg::DCC_A_ON_BIT]
        & (a_level ^ st_reg.ctrl[dcc_pkg::DCC_A_INV_BIT]);
    assign b_result = st_reg.ctrl[dcc_pkg::DCC_B_ON_BIT]
        & (b_level ^ st_reg.ctrl[dcc_pkg::DCC_B_INV_BIT]);

    always_comb
    begin
        logic a_evt;
        logic b_evt;
        logic do_write;
        logic [15:0] wlo;
        logic [15:0] wmask;
        logic [1:0] clr;
        logic [1:0] clr_irq;
        logic [1:0] flags;
        logic [1:0] pending;
        a_evt = 1'b0;
        b_evt = 1'b0;
        do_write = 1'b0;
        wlo = 16'h0000;
        wmask = 16'h0000;
        clr = 2'h0;
        clr_irq = 2'h0;
        flags = 2'h0;
        pending = 2'h0;
        st_next = st_reg;

        st_next.idle_meta = device_idle;
        st_next.idle_sync = st_reg.idle_meta;

        // only raw input edges count; toggling invert alone sets no flag
        a_evt = st_reg.ctrl[dcc_pkg::DCC_A_ON_BIT] & a_change;
        b_evt = st_reg.ctrl[dcc_pkg::DCC_B_ON_BIT] & b_change;

        // write channel capture, either order
        if (!st_reg.aw_held && s_axi_awvalid)
        begin
            st_next.aw_held = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (!st_reg.w_held && s_axi_wvalid)
        begin
            st_next.w_held = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end

        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
        begin
            do_write = 1'b1;
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = dcc_pkg::DCC_AXI_OKAY;
        end
        if (st_reg.bvalid && s_axi_bready)
        begin
            st_next.bvalid = 1'b0;
        end

        wlo = st_reg.wdata[15:0];
        wmask = {{8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};

        if (do_write)
        begin
            case (st_reg.awaddr[11:2])
                dcc_pkg::DCC_CTRL_OFFSET[11:2]:
                begin
                    st_next.ctrl = (st_reg.ctrl & ~(wmask & dcc_pkg::DCC_CTRL_WMASK))
                        | (wlo & wmask & dcc_pkg::DCC_CTRL_WMASK);
                    // writing zero to a flag clears it
                    clr[0] = wmask[dcc_pkg::DCC_A_FLAG_BIT] & ~wlo[dcc_pkg::DCC_A_FLAG_BIT];
                    clr[1] = wmask[dcc_pkg::DCC_B_FLAG_BIT] & ~wlo[dcc_pkg::DCC_B_FLAG_BIT];
                end
                dcc_pkg::DCC_IRQ_STATUS_OFFSET[11:2]:
                begin
                    // separate from the flag clear: a control write keeps pending status
                    clr_irq = st_reg.wdata[1:0] & {2{st_reg.wstrb[0]}};
                end
                dcc_pkg::DCC_IRQ_MASK_OFFSET[11:2]:
                begin
                    if (st_reg.wstrb[0])
                    begin
                        st_next.irq_mask = st_reg.wdata[1:0];
                    end
                end
                default:
                begin
                    st_next.bresp = dcc_pkg::DCC_AXI_SLVERR;
                end
            endcase
        end

        // set wins over clear
        flags = {st_reg.ctrl[dcc_pkg::DCC_B_FLAG_BIT], st_reg.ctrl[dcc_pkg::DCC_A_FLAG_BIT]};
        flags = (flags & ~clr) | {b_evt, a_evt};
        st_next.ctrl[dcc_pkg::DCC_A_FLAG_BIT] = flags[0];
        st_next.ctrl[dcc_pkg::DCC_B_FLAG_BIT] = flags[1];
        st_next.ctrl[dcc_pkg::DCC_A_RESULT_BIT] = a_result;
        st_next.ctrl[dcc_pkg::DCC_B_RESULT_BIT] = b_result;
        st_next.ctrl[dcc_pkg::DCC_RESERVED_BIT] = 1'b0;

        // interrupt status: events are dropped while suppressed in idle
        pending = {b_evt, a_evt};
        if (st_reg.ctrl[dcc_pkg::DCC_IDLE_SUPPRESS_BIT] && st_reg.idle_sync)
        begin
            pending = 2'h0;
        end
        st_next.irq_status = (st_reg.irq_status & ~clr_irq) | pending;
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        // pads follow the same inverted result as status
        st_next.a_pad = a_result;
        st_next.b_pad = b_result;
        st_next.a_oe_n = ~st_next.ctrl[dcc_pkg::DCC_A_PAD_BIT];
        st_next.b_oe_n = ~st_next.ctrl[dcc_pkg::DCC_B_PAD_BIT];

        // read channel
        if (st_reg.rvalid && s_axi_rready)
        begin
            st_next.rvalid = 1'b0;
        end
        if (!st_reg.rvalid && s_axi_arvalid)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp = dcc_pkg::DCC_AXI_OKAY;
            case (s_axi_araddr[11:2])
                dcc_pkg::DCC_CTRL_OFFSET[11:2]:
                    st_next.rdata = {16'h0000, st_reg.ctrl};
                dcc_pkg::DCC_IRQ_STATUS_OFFSET[11:2]:
                    st_next.rdata = {30'h0, st_reg.irq_status};
                dcc_pkg::DCC_IRQ_MASK_OFFSET[11:2]:
                    st_next.rdata = {30'h0, st_reg.irq_mask};
                default:
                begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = dcc_pkg::DCC_AXI_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg <= '0;
            st_reg.ctrl <= dcc_pkg::DCC_CTRL_RESET;
            st_reg.irq_status <= dcc_pkg::DCC_IRQ_RESET;
            st_reg.irq_mask <= dcc_pkg::DCC_IRQ_RESET;
            st_reg.a_oe_n <= 1'b1;
            st_reg.b_oe_n <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // control outputs are register bits, so they come straight from flops
    assign cmp_a_on = st_reg.ctrl[dcc_pkg::DCC_A_ON_BIT];
    assign cmp_b_on = st_reg.ctrl[dcc_pkg::DCC_B_ON_BIT];
    assign cmp_a_plus_route = st_reg.ctrl[dcc_pkg::DCC_A_PLUS_BIT];
    assign cmp_a_minus_route = st_reg.ctrl[dcc_pkg::DCC_A_MINUS_BIT];
    assign cmp_b_plus_route = st_reg.ctrl[dcc_pkg::DCC_B_PLUS_BIT];
    assign cmp_b_minus_route = st_reg.ctrl[dcc_pkg::DCC_B_MINUS_BIT];
    assign cmp_a_pad_out = st_reg.a_pad;
    assign cmp_b_pad_out = st_reg.b_pad;
    assign cmp_a_pad_oe_n = st_reg.a_oe_n;
    assign cmp_b_pad_oe_n = st_reg.b_oe_n;
    assign irq = st_reg.irq;
    assign s_axi_awready = ~st_reg.aw_held;
    assign s_axi_wready = ~st_reg.w_held;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = ~st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
endmodule

// ### testbench/dcc_chk.sv
// port checker for the dual comparator control block
`timescale 1ns/1ps
module dcc_chk
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic cmp_a_on,
    input wire logic cmp_b_on,
    input wire logic cmp_a_pad_out,
    input wire logic cmp_b_pad_out,
    input wire logic cmp_a_pad_oe_n,
    input wire logic irq,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    pad_a_off_a: assert property (!cmp_a_on [*3] |-> !cmp_a_pad_out)
        else $error("pad a driven while off");
    pad_b_off_a: assert property (!cmp_b_on [*3] |-> !cmp_b_pad_out)
        else $error("pad b driven while off");
    reset_state_a: assert property ($rose(resetn) |-> !irq && cmp_a_pad_oe_n && !cmp_b_on)
        else $error("outputs not cleared by reset");
    reserved_zero_a: assert property (s_axi_rvalid |-> !s_axi_rdata[14] && !(|s_axi_rdata[31:16]))
        else $error("reserved read bits set");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    read_excl_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    write_single_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
endmodule
bind dcc_top dcc_chk u_chk (.*);

// ### testbench/dcc_cmp_model.sv
// one analog comparator core with its input routing
`timescale 1ns/1ps
module dcc_cmp_model
(
    input wire logic on,
    input wire logic plus_route,
    input wire logic minus_route,
    input wire logic [15:0] plus_mv,
    input wire logic [15:0] minus_mv,
    input wire logic [15:0] ref_mv,
    output logic raw
);
    logic [15:0] vp;
    logic [15:0] vm;
    assign vp = plus_route ? plus_mv : ref_mv;
    assign vm = minus_route ? plus_mv : minus_mv;
    // powered-down core idles low
    assign raw = on & (vp > vm);
endmodule

// ### testbench/dcc_top_tb.sv
// self-checking bench: registers, events, interrupt, idle
`timescale 1ns/1ps
module dcc_top_tb;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic device_idle = 1'h0;
    logic cmp_a_raw, cmp_b_raw, cmp_a_on, cmp_b_on, irq;
    logic cmp_a_plus_route, cmp_a_minus_route, cmp_b_plus_route, cmp_b_minus_route;
    logic cmp_a_pad_out, cmp_a_pad_oe_n, cmp_b_pad_out, cmp_b_pad_oe_n;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] v[2][3];
    int fails = 0;
    int n_compared = 0;
    int ctl = 0;
    int st = 0;
    int fl[2] = '{0, 0};
    always #25 sys_clk = ~sys_clk;
    dcc_top u_dut (.*);
    dcc_cmp_model u_ma (.on(cmp_a_on), .plus_route(cmp_a_plus_route),
        .minus_route(cmp_a_minus_route), .plus_mv(v[0][0]), .minus_mv(v[0][1]),
        .ref_mv(v[0][2]), .raw(cmp_a_raw));
    dcc_cmp_model u_mb (.on(cmp_b_on), .plus_route(cmp_b_plus_route),
        .minus_route(cmp_b_minus_route), .plus_mv(v[1][0]), .minus_mv(v[1][1]),
        .ref_mv(v[1][2]), .raw(cmp_b_raw));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] x);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    // expected result bit: routed levels, then invert, gated by enable
    function automatic logic res(input int k);
        logic [15:0] p;
        logic [15:0] m;
        p = ctl[2 * k] ? v[k][0] : v[k][2];
        m = ctl[2 * k + 1] ? v[k][0] : v[k][1];
        return ctl[10 + k] & ((p > m) ^ ctl[4 + k]);
    endfunction
    function automatic logic [31:0] ew();
        return ctl & 32'h8F3F | fl[0] << 12 | fl[1] << 13 | res(0) << 6 | res(1) << 7;
    endfunction
    task summarize;
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        summarize();
    end
    initial
    begin
        void'($urandom(32'h1CDC4597));
        v = '{'{16'h0064, 16'h00C8, 16'h0096}, '{16'h0064, 16'h00C8, 16'h0096}};
        repeat (4) @(posedge sys_clk);
        resetn <= 1'h1;
        for (int k = 0; k < 3; k++)
        begin
            rd(12'(k * 4));
            chk("reg reset", d, 32'h0);
        end
        chk("pins reset", {cmp_a_on, cmp_b_on, cmp_a_pad_oe_n, cmp_b_pad_oe_n, irq}, 32'h6);
        $display("reset test done");
        // comparators stay off so results are fixed at zero
        repeat (8)
        begin
            ctl = $urandom & 32'hFFFFF3FF;
            wr(dcc_pkg::DCC_CTRL_OFFSET, ctl);
            rd(dcc_pkg::DCC_CTRL_OFFSET);
            chk("ctrl", d, ew());
            chk("routes", {cmp_b_minus_route, cmp_b_plus_route, cmp_a_minus_route,
                cmp_a_plus_route}, ctl & 32'hF);
            chk("pad enables", {cmp_b_pad_oe_n, cmp_a_pad_oe_n}, ~ctl >> 8 & 32'h3);
        end
        ctl = 32'h0C05;
        wr(dcc_pkg::DCC_CTRL_OFFSET, ctl);
        for (int k = 0; k < 2; k++)
        begin
            v[k][0] <= 16'h012C;
            repeat (4) @(posedge sys_clk);
            fl[k] = 1;
            st |= 1 << k;
            rd(dcc_pkg::DCC_CTRL_OFFSET);
            chk("flag", d, ew());
            rd(dcc_pkg::DCC_IRQ_STATUS_OFFSET);
            chk("status", d, st);
            chk("irq masked", irq, 32'h0);
        end
        wr(dcc_pkg::DCC_IRQ_MASK_OFFSET, 32'h3);
        chk("irq", irq, 32'h1);
        wr(dcc_pkg::DCC_IRQ_STATUS_OFFSET, 32'h3);
        st = 0;
        chk("irq cleared", irq, 32'h0);
        ctl = 32'h0C35;
        wr(dcc_pkg::DCC_CTRL_OFFSET, ctl);
        fl = '{0, 0};
        rd(dcc_pkg::DCC_CTRL_OFFSET);
        chk("inverted", d, ew());
        chk("pads", {cmp_b_pad_out, cmp_a_pad_out}, 32'h0);
        $display("event test done");
        ctl = 32'h8C35;
        wr(dcc_pkg::DCC_CTRL_OFFSET, ctl);
        device_idle <= 1'h1;
        repeat (3) @(posedge sys_clk);
        v[0][0] <= 16'h0064;
        repeat (4) @(posedge sys_clk);
        fl[0] = 1;
        chk("idle irq", irq, 32'h0);
        chk("idle pad", cmp_a_pad_out, 32'h1);
        rd(dcc_pkg::DCC_CTRL_OFFSET);
        chk("idle ctrl", d, ew());
        rd(dcc_pkg::DCC_IRQ_STATUS_OFFSET);
        chk("idle status", d, st);
        device_idle <= 1'h0;
        repeat (3) @(posedge sys_clk);
        v[0][0] <= 16'h012C;
        repeat (4) @(posedge sys_clk);
        st = 1;
        chk("awake irq", irq, 32'h1);
        $display("idle test done");
        ctl = 0;
        wr(dcc_pkg::DCC_CTRL_OFFSET, 32'h0);
        fl = '{0, 0};
        rd(dcc_pkg::DCC_CTRL_OFFSET);
        chk("off", d, ew());
        chk("on pins", {cmp_a_on, cmp_b_on}, 32'h0);
        rd(dcc_pkg::DCC_IRQ_STATUS_OFFSET);
        chk("status kept", d, st);
        // second reset in mid-run with status, mask and irq set
        resetn <= 1'h0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'h1;
        st = 0;
        chk("irq reset", irq, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            rd(12'(k * 4));
            chk("reg rereset", d, 32'h0);
        end
        rd(12'h00C);
        chk("bad read resp", r, 32'h2);
        chk("bad read data", d, 32'h0);
        wr(12'h010, 32'hFFFF);
        chk("bad write resp", r, 32'h2);
        rd(dcc_pkg::DCC_CTRL_OFFSET);
        chk("ctrl kept", d, ew());
        $display("map test done");
        summarize();
    end
endmodule
